// ### rtl/adc_sequence_config.sv
// Notes on behaviour
// - Reference code: 000/1xx supplies, 001 ext high, 010 ext low, 011 both.
// - Scan bit set steps channel 0 input while mux A samples; clear, none.
// - Channel field picks 1, 2 or 4 channels; in 12-bit mode reads zero.
// - Buffer half status is 1 while second half fills; split mode only.
// - No DMA mode: interrupt every N+1 conversions, N = low four rate bits.
// - DMA mode: DMA address steps every N+1 conversions, N = full rate field.
//
// Local design decisions: the strobed register port and the address map.
module adc_sequence_config #(
	parameter int SCAN_INPUTS = 6,
	parameter int SCAN_W = 3
) (
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic [7:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic conversion_done_in,
	input wire logic sample_mux_a_in,
	output logic [15:0] rdata_out,
	output logic ref_high_ext_out,
	output logic ref_low_ext_out,
	output logic scan_enable_out,
	output logic [SCAN_W-1:0] scan_input_out,
	output logic [3:0] channels_active_out,
	output logic split_buffer_mode_out,
	output logic buffer_half_out,
	output logic dma_addr_step_out,
	output logic irq_out
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Conversions per event minus one; top bit ignored without DMA mode
	function automatic logic [4:0] limit_of(input logic [4:0] rate,
		input logic dma);
		limit_of = dma ? rate : {1'b0, rate[3:0]};
	endfunction

	function automatic logic [3:0] chan_mask(input logic [1:0] sel,
		input logic twelve);
		if (twelve || sel == adc_seq_pkg::CHAN_ONE) begin
			chan_mask = adc_seq_pkg::CH_MASK_ONE;
		end else if (sel == adc_seq_pkg::CHAN_TWO) begin
			chan_mask = adc_seq_pkg::CH_MASK_TWO;
		end else begin
			chan_mask = adc_seq_pkg::CH_MASK_FOUR;
		end
	endfunction

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [2:0] reference_select, next_reference_select;
	logic scan_select, next_scan_select;
	logic [1:0] channel_count_select, next_channel_count_select;
	logic [4:0] increment_rate, next_increment_rate;
	logic split_buffer_mode, next_split_buffer_mode;
	logic twelve_bit_select, next_twelve_bit_select;
	logic dma_address_mode_enable, next_dma_address_mode_enable;
	logic [1:0] int_status, next_int_status;
	logic [1:0] int_mask, next_int_mask;
	logic [15:0] next_rdata;
	logic [4:0] sample_count, next_sample_count;
	logic [SCAN_W-1:0] next_scan_input;
	logic next_buffer_half;
	logic next_dma_step;
	logic next_irq;
	logic [2:0] next_ref_code;
	logic next_ref_high, next_ref_low, next_scan_enable;
	logic [3:0] next_channels;

	logic wr_ctrl, wr_mode, wr_status, wr_mask;
	logic [4:0] limit_value;
	logic group_done;
	logic group_event;

	always_comb begin
		wr_ctrl = wr_in && addr_in == adc_seq_pkg::CTRL_OFFSET;
		wr_mode = wr_in && addr_in == adc_seq_pkg::MODE_OFFSET;
		wr_status = wr_in && addr_in == adc_seq_pkg::INT_STATUS_OFFSET;
		wr_mask = wr_in && addr_in == adc_seq_pkg::INT_MASK_OFFSET;
		limit_value = limit_of(increment_rate, dma_address_mode_enable);
		group_done = conversion_done_in && sample_count == limit_value;
		group_event = group_done && !dma_address_mode_enable;
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_comb begin
		next_reference_select = reference_select;
		next_scan_select = scan_select;
		next_channel_count_select = channel_count_select;
		next_increment_rate = increment_rate;
		next_split_buffer_mode = split_buffer_mode;
		next_twelve_bit_select = twelve_bit_select;
		next_dma_address_mode_enable = dma_address_mode_enable;
		next_int_mask = int_mask;
		if (wr_ctrl) begin
			next_reference_select =
				wdata_in[adc_seq_pkg::REF_MSB:adc_seq_pkg::REF_LSB];
			next_scan_select = wdata_in[adc_seq_pkg::SCAN_BIT];
			next_channel_count_select =
				wdata_in[adc_seq_pkg::CHAN_MSB:adc_seq_pkg::CHAN_LSB];
			next_increment_rate =
				wdata_in[adc_seq_pkg::RATE_MSB:adc_seq_pkg::RATE_LSB];
			next_split_buffer_mode = wdata_in[adc_seq_pkg::SPLIT_BIT];
		end
		if (wr_mode) begin
			next_twelve_bit_select = wdata_in[adc_seq_pkg::TWELVE_BIT];
			next_dma_address_mode_enable =
				wdata_in[adc_seq_pkg::DMA_MODE_BIT];
		end
		if (wr_mask) begin
			next_int_mask = wdata_in[adc_seq_pkg::INT_BITS-1:0];
		end
		// A new event beats a write-one-to-clear in the same cycle
		next_int_status = int_status;
		if (wr_status) begin
			next_int_status = int_status &
				~wdata_in[adc_seq_pkg::INT_BITS-1:0];
		end
		next_int_status[adc_seq_pkg::GROUP_DONE_BIT] =
			next_int_status[adc_seq_pkg::GROUP_DONE_BIT] | group_event;
		next_int_status[adc_seq_pkg::DMA_STEP_BIT] =
			next_int_status[adc_seq_pkg::DMA_STEP_BIT] |
			(group_done && dma_address_mode_enable);
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = 16'h0000;
		if (rd_in) begin
			case (addr_in)
				adc_seq_pkg::CTRL_OFFSET: begin
					next_rdata[adc_seq_pkg::REF_MSB:adc_seq_pkg::REF_LSB] =
						reference_select;
					next_rdata[adc_seq_pkg::SCAN_BIT] = scan_select;
					// Field unimplemented in 12-bit operation
					if (!twelve_bit_select) begin
						next_rdata[adc_seq_pkg::CHAN_MSB:adc_seq_pkg::CHAN_LSB] =
							channel_count_select;
					end
					next_rdata[adc_seq_pkg::HALF_BIT] = buffer_half_out;
					next_rdata[adc_seq_pkg::RATE_MSB:adc_seq_pkg::RATE_LSB] =
						increment_rate;
					next_rdata[adc_seq_pkg::SPLIT_BIT] = split_buffer_mode;
				end
				adc_seq_pkg::MODE_OFFSET: begin
					next_rdata[adc_seq_pkg::TWELVE_BIT] = twelve_bit_select;
					next_rdata[adc_seq_pkg::DMA_MODE_BIT] =
						dma_address_mode_enable;
				end
				adc_seq_pkg::INT_STATUS_OFFSET: begin
					next_rdata[adc_seq_pkg::INT_BITS-1:0] = int_status;
				end
				adc_seq_pkg::INT_MASK_OFFSET: begin
					next_rdata[adc_seq_pkg::INT_BITS-1:0] = int_mask;
				end
				default: begin
					next_rdata = 16'h0000;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Sequencing
	// ----------------------------------------------------------------
	always_comb begin
		// Reprogramming restarts the count so no stale limit is crossed
		if (wr_ctrl || wr_mode) begin
			next_sample_count = 5'h00;
		end else if (group_done) begin
			next_sample_count = 5'h00;
		end else if (conversion_done_in) begin
			next_sample_count = sample_count + 5'h01;
		end else begin
			next_sample_count = sample_count;
		end
		next_dma_step = group_done && dma_address_mode_enable;

		next_buffer_half = buffer_half_out;
		if (!split_buffer_mode) begin
			next_buffer_half = 1'b0;
		end else if (group_done) begin
			next_buffer_half = !buffer_half_out;
		end

		next_scan_input = scan_input_out;
		if (!scan_select) begin
			next_scan_input = '0;
		end else if (conversion_done_in && sample_mux_a_in) begin
			if (scan_input_out == SCAN_W'(SCAN_INPUTS - 1)) begin
				next_scan_input = '0;
			end else begin
				next_scan_input = scan_input_out + SCAN_W'(1);
			end
		end

		// Codes 1xx fall back to the analog supplies
		next_ref_code = reference_select;
		if (reference_select[adc_seq_pkg::REF_MSB - adc_seq_pkg::REF_LSB]) begin
			next_ref_code = adc_seq_pkg::REF_RESET;
		end
		next_ref_high = next_ref_code == adc_seq_pkg::REF_EXT_HIGH ||
			next_ref_code == adc_seq_pkg::REF_EXT_BOTH;
		next_ref_low = next_ref_code == adc_seq_pkg::REF_EXT_LOW ||
			next_ref_code == adc_seq_pkg::REF_EXT_BOTH;
		next_scan_enable = scan_select && sample_mux_a_in;
		next_channels = chan_mask(channel_count_select,
			twelve_bit_select);
		next_irq = |(int_status & int_mask);
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reference_select <= adc_seq_pkg::REF_RESET;
			scan_select <= 1'b0;
			channel_count_select <= adc_seq_pkg::CHAN_RESET;
			increment_rate <= adc_seq_pkg::RATE_RESET;
			split_buffer_mode <= 1'b0;
			twelve_bit_select <= 1'b0;
			dma_address_mode_enable <= 1'b0;
			int_status <= adc_seq_pkg::INT_RESET;
			int_mask <= adc_seq_pkg::INT_RESET;
			sample_count <= 5'h00;
			rdata_out <= 16'h0000;
			ref_high_ext_out <= 1'b0;
			ref_low_ext_out <= 1'b0;
			scan_enable_out <= 1'b0;
			scan_input_out <= '0;
			channels_active_out <= adc_seq_pkg::CH_MASK_ONE;
			split_buffer_mode_out <= 1'b0;
			buffer_half_out <= 1'b0;
			dma_addr_step_out <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			reference_select <= next_reference_select;
			scan_select <= next_scan_select;
			channel_count_select <= next_channel_count_select;
			increment_rate <= next_increment_rate;
			split_buffer_mode <= next_split_buffer_mode;
			twelve_bit_select <= next_twelve_bit_select;
			dma_address_mode_enable <= next_dma_address_mode_enable;
			int_status <= next_int_status;
			int_mask <= next_int_mask;
			sample_count <= next_sample_count;
			rdata_out <= next_rdata;
			ref_high_ext_out <= next_ref_high;
			ref_low_ext_out <= next_ref_low;
			scan_enable_out <= next_scan_enable;
			scan_input_out <= next_scan_input;
			channels_active_out <= next_channels;
			split_buffer_mode_out <= split_buffer_mode;
			buffer_half_out <= next_buffer_half;
			dma_addr_step_out <= next_dma_step;
			irq_out <= next_irq;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);

	ref_ext_high_a: assert property (
		reference_select == adc_seq_pkg::REF_EXT_HIGH
		|=> ref_high_ext_out && !ref_low_ext_out)
		else $error("external high reference not selected");
	ref_fallback_a: assert property (reference_select[2]
		|=> !ref_high_ext_out && !ref_low_ext_out)
		else $error("upper codes must use analog supplies");
	scan_idle_a: assert property (!scan_select
		|=> scan_input_out == '0)
		else $error("scan input moved while scan is off");
	chan_twelve_a: assert property (twelve_bit_select
		|=> channels_active_out == adc_seq_pkg::CH_MASK_ONE)
		else $error("12-bit mode must convert channel 0 only");
	chan_read_a: assert property (rd_in && twelve_bit_select &&
		addr_in == adc_seq_pkg::CTRL_OFFSET
		|=> rdata_out[adc_seq_pkg::CHAN_MSB:adc_seq_pkg::CHAN_LSB] == 2'h0)
		else $error("channel field must read zero in 12-bit mode");
	half_split_a: assert property (!split_buffer_mode
		|=> !buffer_half_out)
		else $error("buffer half set outside split mode");
	group_irq_a: assert property (group_done && !dma_address_mode_enable
		|=> int_status[adc_seq_pkg::GROUP_DONE_BIT] && !dma_addr_step_out)
		else $error("group interrupt missing");
	// Control and mode writes restart the count, so it never sits above its limit
	count_bound_a: assert property (sample_count <= limit_value)
		else $error("sample count passed its limit");
	dma_step_a: assert property (group_done && dma_address_mode_enable
		|=> dma_addr_step_out ##1 !dma_addr_step_out)
		else $error("dma step must be a single pulse");
	irq_level_a: assert property (
		irq_out == |($past(int_status) & $past(int_mask)))
		else $error("interrupt output does not follow status");

	group_cov_c: cover property (group_event ##2 irq_out);
	dma_cov_c: cover property (dma_addr_step_out && limit_value == 5'h1f);
	half_cov_c: cover property (buffer_half_out ##[1:64] !buffer_half_out);
	scan_cov_c: cover property (scan_select && scan_input_out != '0);

endmodule // adc_sequence_config

// ### rtl/adc_seq_pkg.sv
package adc_seq_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] MODE_OFFSET = 8'h04;
	localparam logic [7:0] INT_STATUS_OFFSET = 8'h08;
	localparam logic [7:0] INT_MASK_OFFSET = 8'h0c;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int REF_LSB = 13;
	localparam int REF_MSB = 15;
	localparam int SCAN_BIT = 10;
	localparam int CHAN_LSB = 8;
	localparam int CHAN_MSB = 9;
	localparam int HALF_BIT = 7;
	localparam int RATE_LSB = 2;
	localparam int RATE_MSB = 6;
	localparam int SPLIT_BIT = 1;

	// Mode register fields
	localparam int TWELVE_BIT = 0;
	localparam int DMA_MODE_BIT = 1;

	// Interrupt status and mask fields
	localparam int GROUP_DONE_BIT = 0;
	localparam int DMA_STEP_BIT = 1;
	localparam int INT_BITS = 2;

	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] REF_RESET = 3'h0;
	localparam logic [2:0] REF_EXT_HIGH = 3'h1;
	localparam logic [2:0] REF_EXT_LOW = 3'h2;
	localparam logic [2:0] REF_EXT_BOTH = 3'h3;
	localparam logic [1:0] CHAN_RESET = 2'h0;
	localparam logic [1:0] CHAN_ONE = 2'h0;
	localparam logic [1:0] CHAN_TWO = 2'h1;
	localparam logic [3:0] CH_MASK_ONE = 4'h1;
	localparam logic [3:0] CH_MASK_TWO = 4'h3;
	localparam logic [3:0] CH_MASK_FOUR = 4'hf;
	localparam logic [4:0] RATE_RESET = 5'h00;
	localparam logic [INT_BITS-1:0] INT_RESET = 2'h0;
endpackage

// ### tb/adc_sequence_config_bench.sv
module adc_sequence_config_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [15:0] wdata_in = 16'h0000;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic conversion_done_in = 1'b0;
	logic sample_mux_a_in = 1'b0;
	logic [15:0] rdata_out;
	logic ref_high_ext_out, ref_low_ext_out, scan_enable_out;
	logic [2:0] scan_input_out;
	logic [3:0] channels_active_out;
	logic split_buffer_mode_out, buffer_half_out, dma_addr_step_out, irq_out;
	int errors = 0;
	int checked = 0;
	int steps = 0;
	int base;
	logic [15:0] rd_val;

	adc_sequence_config i_adc_sequence_config (
		.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .conversion_done_in(conversion_done_in),
		.sample_mux_a_in(sample_mux_a_in), .rdata_out(rdata_out),
		.ref_high_ext_out(ref_high_ext_out),
		.ref_low_ext_out(ref_low_ext_out),
		.scan_enable_out(scan_enable_out), .scan_input_out(scan_input_out),
		.channels_active_out(channels_active_out),
		.split_buffer_mode_out(split_buffer_mode_out),
		.buffer_half_out(buffer_half_out),
		.dma_addr_step_out(dma_addr_step_out), .irq_out(irq_out)
	);

	always #5 core_clk_in = ~core_clk_in;

	// Step pulses are one cycle wide, so counting them proves the spacing
	always @(posedge core_clk_in) begin
		if (dma_addr_step_out === 1'b1) begin
			steps <= steps + 1;
		end
	end

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic test_done();
		if (errors == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge core_clk_in);
		wr_in <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge core_clk_in);
		rd_in <= 1'b0;
		@(negedge core_clk_in);
		rd_val = rdata_out;
	endtask

	task automatic convert(input int n);
		@(posedge core_clk_in);
		repeat (n) begin
			conversion_done_in <= 1'b1;
			@(posedge core_clk_in);
		end
		conversion_done_in <= 1'b0;
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge core_clk_in);
		@(negedge core_clk_in);
	endtask

	function automatic logic [15:0] ctrl(input logic [2:0] r,
			input logic s, input logic [1:0] c, input logic [4:0] n,
			input logic b);
		ctrl = (16'(r) << adc_seq_pkg::REF_LSB)
			| (16'(s) << adc_seq_pkg::SCAN_BIT)
			| (16'(c) << adc_seq_pkg::CHAN_LSB)
			| (16'(n) << adc_seq_pkg::RATE_LSB)
			| (16'(b) << adc_seq_pkg::SPLIT_BIT);
	endfunction

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge core_clk_in);
		errors++;
		test_done();
	end

	initial begin
		repeat (8) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		wait_n(1);
		chk(16'(channels_active_out), 16'h0001);
		chk(16'({irq_out, buffer_half_out}), 16'h0000);
		rd(8'h00);
		chk(rd_val, 16'h0000);
		wr(8'h10, 16'hffff);
		rd(8'h10);
		chk(rd_val, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			wr(8'h00, ctrl(3'(i), 1'b0, 2'h0, 5'h00, 1'b0));
			wait_n(1);
			chk(16'({ref_high_ext_out, ref_low_ext_out}),
				(i == 1) ? 16'h2 : (i == 2) ? 16'h1 :
				(i == 3) ? 16'h3 : 16'h0);
		end
		for (int c = 0; c < 4; c++) begin
			wr(8'h00, ctrl(3'h0, 1'b0, 2'(c), 5'h00, 1'b0));
			wait_n(1);
			chk(16'(channels_active_out),
				(c == 0) ? 16'h1 : (c == 1) ? 16'h3 : 16'hf);
			rd(8'h00);
			chk(rd_val, 16'(c) << 8);
		end
		wr(8'h04, 16'h0001);
		rd(8'h00);
		chk(rd_val, 16'h0000);
		chk(16'(channels_active_out), 16'h0001);
		wr(8'h04, 16'h0000);
		// Scan walks channel 0 through the inputs, wrapping after the last
		wr(8'h00, ctrl(3'h0, 1'b1, 2'h0, 5'h00, 1'b0));
		sample_mux_a_in <= 1'b1;
		convert(8);
		wait_n(1);
		chk(16'({scan_enable_out, scan_input_out}), 16'h000a);
		sample_mux_a_in <= 1'b0;
		convert(3);
		wait_n(1);
		chk(16'({scan_enable_out, scan_input_out}), 16'h0002);
		wr(8'h00, ctrl(3'h0, 1'b0, 2'h0, 5'h00, 1'b0));
		sample_mux_a_in <= 1'b1;
		convert(2);
		wait_n(1);
		chk(16'({scan_enable_out, scan_input_out}), 16'h0000);
		sample_mux_a_in <= 1'b0;
		// Scan runs used rate 0, so the group flag is already set
		wr(8'h08, 16'h0003);
		// Top bit of the rate is ignored without DMA: 5'h11 means every 2nd
		wr(8'h0c, 16'h0003);
		wr(8'h00, ctrl(3'h0, 1'b0, 2'h0, 5'h11, 1'b0));
		convert(1);
		rd(8'h08);
		chk(rd_val, 16'h0000);
		convert(1);
		wait_n(2);
		chk(16'(irq_out), 16'h0001);
		rd(8'h08);
		chk(rd_val, 16'h0001);
		wr(8'h08, 16'h0001);
		wait_n(1);
		chk(16'(irq_out), 16'h0000);
		wr(8'h00, ctrl(3'h0, 1'b0, 2'h0, 5'h0f, 1'b0));
		convert(15);
		rd(8'h08);
		chk(rd_val, 16'h0000);
		convert(1);
		wr(8'h0c, 16'h0000);
		wait_n(1);
		chk(16'(irq_out), 16'h0000);
		rd(8'h08);
		chk(rd_val, 16'h0001);
		wr(8'h0c, 16'h0003);
		wait_n(1);
		chk(16'(irq_out), 16'h0001);
		wr(8'h08, 16'h0003);
		// Split buffer: half indicator flips on every completed group
		wr(8'h00, ctrl(3'h0, 1'b0, 2'h0, 5'h00, 1'b1));
		convert(1);
		wait_n(1);
		chk(16'({split_buffer_mode_out, buffer_half_out}), 16'h3);
		rd(8'h00);
		chk(rd_val, 16'h0082);
		convert(1);
		wait_n(1);
		chk(16'(buffer_half_out), 16'h0000);
		wr(8'h08, 16'h0003);
		// DMA mode uses all five rate bits: every 32nd, then every 2nd
		wr(8'h04, 16'h0002);
		wr(8'h00, ctrl(3'h0, 1'b0, 2'h0, 5'h1f, 1'b0));
		base = steps;
		convert(31);
		wait_n(2);
		chk(16'(steps - base), 16'h0000);
		convert(1);
		wait_n(2);
		chk(16'(steps - base), 16'h0001);
		rd(8'h08);
		chk(rd_val, 16'h0002);
		wr(8'h00, ctrl(3'h0, 1'b0, 2'h0, 5'h01, 1'b0));
		base = steps;
		convert(5);
		wait_n(2);
		chk(16'(steps - base), 16'h0002);
		test_done();
	end
endmodule // adc_sequence_config_bench
